// File: iof_pkg.sv
// Shared constants, types and register map for the I/O pin function select block
package iof_pkg;

  // Pin count and register geometry
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned REG_WIDTH = 16;
  localparam int unsigned BITS_PER_BYTE = 8;

  // Register pointer values carried in the pointer byte
  localparam logic [7:0] PTR_GEN_CTRL = 8'h00;
  localparam logic [7:0] PTR_ANALOG_IN = 8'h01;
  localparam logic [7:0] PTR_ANALOG_OUT = 8'h02;
  localparam logic [7:0] PTR_PULLDOWN = 8'h03;

  // Field positions
  localparam int unsigned LOCK_BIT = 7;

  // Reset values
  localparam logic [NUM_PINS-1:0] ANALOG_IN_RESET = 8'h00;
  localparam logic [NUM_PINS-1:0] ANALOG_OUT_RESET = 8'h00;
  localparam logic [NUM_PINS-1:0] PULLDOWN_RESET = 8'hff;
  localparam logic LOCK_RESET = 1'b0;

  // Bus address of this device on the serial host bus
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

  // Per-pin function selections driven to the pad ring
  typedef struct packed {
    logic [NUM_PINS-1:0] analog_in_sel;
    logic [NUM_PINS-1:0] analog_out_sel;
    logic [NUM_PINS-1:0] weak_pd_sel;
  } iof_pin_cfg_s;

  // Register selected by a pointer byte
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_GEN_CTRL = 3'h1,
    SEL_ANALOG_IN = 3'h2,
    SEL_ANALOG_OUT = 3'h3,
    SEL_PULLDOWN = 3'h4
  } iof_sel_e;

  // Serial slave states, Gray along the write path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK = 4'h3,
    ST_RXB = 4'h2,
    ST_TXB = 4'h6,
    ST_MACK = 4'h7
  } iof_state_e;

  // Position of a received byte within a write
  typedef enum logic [1:0] {
    IDX_PTR = 2'h0,
    IDX_MSB = 2'h1,
    IDX_LSB = 2'h2
  } iof_idx_e;

endpackage

// File: iof_sync.sv
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module iof_sync #(
  parameter int unsigned WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Asynchronous inputs and filtered levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  typedef struct packed {
    logic [WIDTH-1:0] f1;
    logic [WIDTH-1:0] f2;
    logic [WIDTH-1:0] f3;
    logic [WIDTH-1:0] level;
  } iof_sync_st_s;

  iof_sync_st_s st;
  iof_sync_st_s next_st;

  // Shift chain; level follows once second and third stages agree
  always_comb begin
    next_st = st;
    next_st.f1 = i_async;
    next_st.f2 = st.f1;
    next_st.f3 = st.f2;
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (st.f2[i] == st.f3[i]) begin
        next_st.level[i] = st.f3[i];
      end
    end
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign o_level = st.level;

endmodule // iof_sync

// File: iof_pin_select.sv
// Pin function select registers behind a serial two-wire host interface
`timescale 1ns/1ps
module iof_pin_select #(
  parameter logic [6:0] DEV_ADDR = iof_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Serial host bus, data line open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  // Pin configuration to the pad ring
  output iof_pkg::iof_pin_cfg_s o_pin_cfg,
  output logic o_cfg_lock
);
  import iof_pkg::*;

  typedef struct packed {
    iof_state_e state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    iof_idx_e byte_idx;
    logic [7:0] ptr;
    logic [7:0] msb_buf;
    logic rd_half;
    logic host_ack;
    logic scl_q;
    logic sda_q;
    logic sda_out;
    logic sda_oe_n;
    iof_pin_cfg_s cfg;
    logic lock;
  } iof_st_s;

  localparam logic [3:0] BYTE_BITS = 4'(BITS_PER_BYTE);
  localparam logic [3:0] LAST_BIT = 4'(BITS_PER_BYTE - 1);

  iof_st_s st;
  iof_st_s next_st;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  iof_sel_e cur_sel;
  logic [REG_WIDTH-1:0] rd_word;
  logic [REG_WIDTH-1:0] wr_word;

  // Pointer byte to register selection
  function automatic iof_sel_e reg_sel(input logic [7:0] ptr);
    if (ptr == PTR_GEN_CTRL) begin
      return SEL_GEN_CTRL;
    end else if (ptr == PTR_ANALOG_IN) begin
      return SEL_ANALOG_IN;
    end else if (ptr == PTR_ANALOG_OUT) begin
      return SEL_ANALOG_OUT;
    end else if (ptr == PTR_PULLDOWN) begin
      return SEL_PULLDOWN;
    end else begin
      return SEL_NONE;
    end
  endfunction

  // Read value of a register, reserved bits as zero
  function automatic logic [REG_WIDTH-1:0] read_word(input iof_sel_e sel,
                                                     input iof_pin_cfg_s cfg,
                                                     input logic lock);
    logic [REG_WIDTH-1:0] w;
    w = '0;
    case (sel)
      SEL_GEN_CTRL: w[LOCK_BIT] = lock;
      SEL_ANALOG_IN: w[NUM_PINS-1:0] = cfg.analog_in_sel;
      SEL_ANALOG_OUT: w[NUM_PINS-1:0] = cfg.analog_out_sel;
      SEL_PULLDOWN: w[NUM_PINS-1:0] = cfg.weak_pd_sel;
      default: w = '0;
    endcase
    return w;
  endfunction

  // Bus line synchroniser
  iof_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h3)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_async({i_scl, i_sda}),
    .o_level({scl_s, sda_s})
  );

  // Bus edge and condition detection
  assign scl_rise = scl_s & ~st.scl_q;
  assign scl_fall = ~scl_s & st.scl_q;
  assign start_cond = scl_s & st.scl_q & st.sda_q & ~sda_s;
  assign stop_cond = scl_s & st.scl_q & ~st.sda_q & sda_s;
  assign cur_sel = reg_sel(st.ptr);
  assign rd_word = read_word(cur_sel, st.cfg, st.lock);
  assign wr_word = {st.msb_buf, st.shreg};

  // Slave sequencer and register updates
  always_comb begin
    next_st = st;
    next_st.scl_q = scl_s;
    next_st.sda_q = sda_s;
    if (start_cond) begin
      next_st.state = ST_ADDR;
      next_st.bitcnt = '0;
      next_st.sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      next_st.state = ST_IDLE;
      next_st.sda_oe_n = 1'b1;
    end else begin
      case (st.state)
        ST_IDLE: begin
          next_st.sda_oe_n = 1'b1;
        end
        ST_ADDR, ST_RXB: begin
          if (scl_rise && st.bitcnt < BYTE_BITS) begin
            next_st.shreg = {st.shreg[6:0], sda_s};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall && st.bitcnt == BYTE_BITS) begin
            next_st.bitcnt = '0;
            if (st.state == ST_ADDR) begin
              if (st.shreg[7:1] == DEV_ADDR) begin
                next_st.rw = st.shreg[0];
                next_st.byte_idx = IDX_PTR;
                next_st.state = ST_ACK;
                next_st.sda_oe_n = 1'b0;
              end else begin
                next_st.state = ST_IDLE;
              end
            end else begin
              next_st.state = ST_ACK;
              next_st.sda_oe_n = 1'b0;
              case (st.byte_idx)
                IDX_PTR: begin
                  next_st.ptr = st.shreg;
                  next_st.byte_idx = IDX_MSB;
                end
                IDX_MSB: begin
                  next_st.msb_buf = st.shreg;
                  next_st.byte_idx = IDX_LSB;
                end
                default: begin
                  next_st.byte_idx = IDX_MSB;
                  // Upper byte is dropped for pin registers
                  case (cur_sel)
                    SEL_GEN_CTRL: next_st.lock = wr_word[LOCK_BIT];
                    SEL_ANALOG_IN: begin
                      if (!st.lock) begin
                        next_st.cfg.analog_in_sel = wr_word[NUM_PINS-1:0];
                      end
                    end
                    SEL_ANALOG_OUT: begin
                      if (!st.lock) begin
                        next_st.cfg.analog_out_sel = wr_word[NUM_PINS-1:0];
                      end
                    end
                    SEL_PULLDOWN: begin
                      if (!st.lock) begin
                        next_st.cfg.weak_pd_sel = wr_word[NUM_PINS-1:0];
                      end
                    end
                    default: begin
                      next_st.lock = st.lock;
                    end
                  endcase
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (st.rw) begin
              next_st.shreg = rd_word[REG_WIDTH-1:BITS_PER_BYTE];
              next_st.rd_half = 1'b0;
              next_st.sda_oe_n = rd_word[REG_WIDTH-1];
              next_st.state = ST_TXB;
            end else begin
              next_st.sda_oe_n = 1'b1;
              next_st.state = ST_RXB;
            end
          end
        end
        ST_TXB: begin
          if (scl_fall) begin
            if (st.bitcnt == LAST_BIT) begin
              next_st.bitcnt = '0;
              next_st.sda_oe_n = 1'b1;
              next_st.state = ST_MACK;
            end else begin
              next_st.bitcnt = st.bitcnt + 4'h1;
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.sda_oe_n = st.shreg[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            next_st.host_ack = ~sda_s;
          end else if (scl_fall) begin
            if (st.host_ack) begin
              next_st.rd_half = ~st.rd_half;
              next_st.shreg = st.rd_half ? rd_word[REG_WIDTH-1:BITS_PER_BYTE]
                                         : rd_word[BITS_PER_BYTE-1:0];
              next_st.sda_oe_n = st.rd_half ? rd_word[REG_WIDTH-1]
                                            : rd_word[BITS_PER_BYTE-1];
              next_st.state = ST_TXB;
            end else begin
              next_st.state = ST_IDLE;
            end
          end
        end
        default: begin
          next_st.state = ST_IDLE;
          next_st.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.byte_idx <= IDX_PTR;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.sda_oe_n <= 1'b1;
      st.cfg.analog_in_sel <= ANALOG_IN_RESET;
      st.cfg.analog_out_sel <= ANALOG_OUT_RESET;
      st.cfg.weak_pd_sel <= PULLDOWN_RESET;
      st.lock <= LOCK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state; a clear bit leaves the pin to other logic
  assign o_pin_cfg = st.cfg;
  assign o_cfg_lock = st.lock;
  assign o_sda_out = st.sda_out;
  assign o_sda_oe_n = st.sda_oe_n;

endmodule // iof_pin_select

// File: iof_props.sv
// Property checker for the pin function select block
`timescale 1ns/1ps
module iof_props (
  // Watched ports
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire iof_pkg::iof_pin_cfg_s o_pin_cfg,
  input wire logic o_cfg_lock
);
  import iof_pkg::*;
  // Single clock domain
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  // Values at the first edge after reset
  a_ain_reset: assert property ($rose(i_arst_n) |-> o_pin_cfg.analog_in_sel == 8'h00)
    else $error("analog input select not zero after reset");
  a_aout_reset: assert property ($rose(i_arst_n) |-> o_pin_cfg.analog_out_sel == 8'h00)
    else $error("analog output select not zero after reset");
  a_pd_reset: assert property ($rose(i_arst_n) |-> o_pin_cfg.weak_pd_sel == 8'hff)
    else $error("pull-down select not all ones after reset");
  // Locked contents stay put
  a_locked_hold: assert property ($past(o_cfg_lock) |-> $stable(o_pin_cfg))
    else $error("pin configuration changed while locked");
  // Updates land only with the acknowledge of a written word
  a_cfg_with_ack: assert property ($changed(o_pin_cfg) |-> ##[0:2] !o_sda_oe_n)
    else $error("pin configuration changed outside a write");
  a_lock_with_ack: assert property ($changed(o_cfg_lock) |-> ##[0:2] !o_sda_oe_n)
    else $error("lock changed outside a write");
  // An analog input write leaves the other selections alone
  a_other_fields: assert property ($changed(o_pin_cfg.analog_in_sel) |->
    $stable(o_pin_cfg.analog_out_sel) && $stable(o_pin_cfg.weak_pd_sel))
    else $error("analog input write disturbed other selections");
  // Data line taken only while the bus clock is low
  a_drive_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl && !$past(i_scl, 2))
    else $error("data line driven outside clock low phase");
  // Main scenarios
  c_lock: cover property ($rose(o_cfg_lock));
  c_pd_change: cover property ($changed(o_pin_cfg.weak_pd_sel));
  c_out_change: cover property ($changed(o_pin_cfg.analog_out_sel));
endmodule // iof_props

bind iof_pin_select iof_props iof_props_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
  .o_pin_cfg(o_pin_cfg), .o_cfg_lock(o_cfg_lock));

// File: iof_host.sv
// Two-wire bus host model that reaches the configuration registers
`timescale 1ns/1ps
module iof_host (
  // Clock and data wire level
  input wire logic i_mclk,
  input wire logic i_sda,
  // Bus lines, data high means released
  output logic o_scl,
  output logic o_sda
);
  import iof_pkg::*;
  localparam int H = 10; // Phase length, above the 8 mclk minimum
  int nak = 0;
  // Idle bus
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // One bus phase
  task automatic st(input logic c, input logic d);
    o_scl = c;
    o_sda = d;
    repeat (H) @(negedge i_mclk);
  endtask
  // Start, also repeated
  task automatic sta();
    st(1'b0, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
    st(1'b0, 1'b0);
  endtask
  // Stop
  task automatic sto();
    st(1'b0, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
  endtask
  // Byte out and in, MSB first, then the acknowledge bit
  task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      st(1'b0, d[i]);
      st(1'b1, d[i]);
      q[i] = i_sda;
      st(1'b0, d[i]);
    end
    st(1'b0, a);
    st(1'b1, a);
    k = i_sda;
    st(1'b0, a);
  endtask
  // Word write: pointer, then MSB and LSB
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    logic [7:0] q;
    logic [3:0] k;
    sta();
    xb({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q, k[0]);
    xb(p, 1'b1, q, k[1]);
    xb(v[15:8], 1'b1, q, k[2]);
    xb(v[7:0], 1'b1, q, k[3]);
    sto();
    nak += $countones(k);
  endtask
  // Word read: pointer, repeated start, MSB acked, LSB not acked
  task automatic rd(input logic [7:0] p, output logic [15:0] v);
    logic [7:0] q;
    logic [3:0] k;
    sta();
    xb({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q, k[0]);
    xb(p, 1'b1, q, k[1]);
    sta();
    xb({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, q, k[2]);
    xb(8'hff, 1'b0, v[15:8], k[3]);
    xb(8'hff, 1'b1, v[7:0], k[3]);
    sto();
    nak += $countones(k[2:0]);
  endtask
  // Address byte alone to a chosen address; k high means no acknowledge
  task automatic probe(input logic [6:0] a, output logic k);
    logic [7:0] q;
    sta();
    xb({a, 1'b0}, 1'b1, q, k);
    sto();
  endtask
endmodule // iof_host

// File: tb_top.sv
// Self-checking bench for the pin function select block
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_top;
  import iof_pkg::*;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic scl, hsda, sda, sda_out, oe_n, lock;
  iof_pin_cfg_s cfg;
  logic [15:0] r;
  logic nk;
  int miscompares = 0;
  int comparisons = 0;
  int m[4]; // Model: 0 control, 1 analog in, 2 analog out, 3 pull-down
  // Clock and open-drain data wire with pull-up
  always #4 i_mclk = ~i_mclk;
  assign sda = hsda & (oe_n ? 1'b1 : sda_out);
  iof_pin_select iof_pin_select_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_scl(scl),
    .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(oe_n), .o_pin_cfg(cfg), .o_cfg_lock(lock));
  iof_host iof_host_i (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));
  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Write through the bus and update the model
  task automatic put(input int p, input logic [15:0] v);
    iof_host_i.wr(p[7:0], v);
    if (p == 0)
      m[0] = int'(v & 16'h0080);
    else if (m[0][7] == 1'b0)
      m[p] = int'(v & 16'h00ff);
  endtask
  // Compare outputs and read back all registers
  task automatic chk_all();
    `CHK("pin_cfg", {m[1][7:0], m[2][7:0], m[3][7:0]}, cfg)
    `CHK("lock", m[0][7], lock)
    for (int p = 0; p < 4; p++) begin
      iof_host_i.rd(p[7:0], r);
      `CHK("readback", m[p][15:0], r)
    end
  endtask
  // Reset with model defaults
  task automatic do_reset();
    i_arst_n = 1'b0;
    m = '{0, 0, 0, 32'h000000ff};
    repeat (8) @(negedge i_mclk);
    i_arst_n = 1'b1;
    repeat (8) @(negedge i_mclk);
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(negedge i_mclk);
    miscompares++;
    finish_test();
  end
  // Main sequence
  initial begin
    void'($urandom(47122));
    do_reset();
    chk_all();
    for (int p = 1; p < 4; p++)
      put(p, 16'($urandom));
    chk_all();
    // Unmapped pointer: write dropped, reads zero; other address: no acknowledge
    iof_host_i.wr(8'h04, 16'($urandom));
    iof_host_i.rd(8'h04, r);
    `CHK("unmapped", 16'h0000, r)
    iof_host_i.probe(DEV_ADDR_DEFAULT ^ 7'h01, nk);
    `CHK("stranger_nack", 1'b1, nk)
    for (int i = 0; i < 8; i++) begin
      put(3, 16'h0001 << i);
      `CHK("pd_walk", 8'h01 << i, cfg.weak_pd_sel)
    end
    put(0, 16'hff80);
    for (int p = 1; p < 4; p++)
      put(p, 16'($urandom));
    chk_all();
    put(0, 16'h0000);
    put(2, 16'($urandom));
    put(1, 16'($urandom));
    chk_all();
    do_reset();
    chk_all();
    `CHK("nacks", 0, iof_host_i.nak)
    finish_test();
  end
endmodule // tb_top
